// [hw/tci_pkg.sv]
// Package of constants for the three channel interval timer
package tci_pkg;
    // ------------------------------------------------------------
    // Port addresses and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_CNT0     = 8'h40;
    localparam logic [7:0] PORT_CNT1     = 8'h41;
    localparam logic [7:0] PORT_CNT2     = 8'h42;
    localparam logic [7:0] PORT_CMD      = 8'h43;
    localparam logic [1:0] SEL_READBACK  = 2'h3;
    localparam logic [1:0] ACC_LATCH     = 2'h0;
    localparam logic [1:0] ACC_LSB       = 2'h1;
    localparam logic [1:0] ACC_MSB       = 2'h2;
    localparam logic [1:0] ACC_WORD      = 2'h3;
    localparam logic [1:0] MODE_RATE     = 2'h2;
    localparam logic [1:0] MODE_SQUARE   = 2'h3;
    localparam int         CW_SEL_HI     = 7;
    localparam int         CW_SEL_LO     = 6;
    localparam int         CW_ACC_HI     = 5;
    localparam int         CW_ACC_LO     = 4;
    localparam int         CW_MODE_HI    = 3;
    localparam int         CW_MODE_LO    = 1;
    localparam int         CW_BCD        = 0;
    localparam int         RB_COUNT_N    = 5;
    localparam int         RB_STATUS_N   = 4;
    localparam logic [7:0] READ_IDLE     = 8'hff;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         CNT_DIV       = 12;
    localparam logic [3:0] CNT_DIV_LAST  = 4'(CNT_DIV - 1);
    localparam logic [2:0] RST_MODE      = 3'h0;
endpackage : tci_pkg

// [hw/tci_timer.sv]
// Three channel interval timer with command port and count ports
`timescale 1ns/100ps
// Contract
// - Count loads one count period after write, while its gate is high
// - Square wave starts high, steps two, toggles
// - Square period equals count times period for even counts
// - Rate mode pulses low one period at one
// - Tone frequency equals clock over count for even counts
// - Address 11 write stores command word
// - Command word is write only
// - Decode counter, mode, BCD, access format
// - New count keeps programmed mode
// - Three count ports by address lines
// - Gates 0,1 tied high; gate2 external
// - Latch freezes count until read or reprogram
// - Second latch before read is ignored
// - Byte sequence tracked per counter
// - Readback count bit low latches counts
// - Readback status bit low latches status
// - Repeated status latch ignored until read
// - Both bits low latch count and status
// - Status read first, then count, then live
module tci_timer (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [1:0] addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    input  wire logic       speaker_gate,
    output logic            system_tick_interrupt,
    output logic            refresh_request,
    output logic            speaker_tone
);
    // ------------------------------------------------------------
    // Count enable divider
    // ------------------------------------------------------------
    logic [3:0] div_r, div_nxt;
    logic       cnt_en;
    always_comb begin
        cnt_en  = (div_r == tci_pkg::CNT_DIV_LAST);
        div_nxt = cnt_en ? 4'h0 : div_r + 4'h1;
    end
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            div_r <= 4'h0;
        end else begin
            div_r <= div_nxt;
        end
    end
    // ------------------------------------------------------------
    // Per-counter state
    // ------------------------------------------------------------
    logic [15:0] ce_r [3], ce_nxt [3], init_r [3], init_nxt [3];
    logic [15:0] output_latch_r [3], output_latch_nxt [3];
    logic [2:0]  mode_r [3], mode_nxt [3];
    logic [1:0]  acc_r [3], acc_nxt [3];
    logic [7:0]  st_r [3], st_nxt [3];
    logic [2:0]  bcd_r, bcd_nxt, out_r, out_nxt, null_r, null_nxt, pend_r, pend_nxt;
    logic [2:0]  olv_r, olv_nxt, stv_r, stv_nxt, wph_r, wph_nxt, rph_r, rph_nxt;
    logic [2:0]  gate;
    logic [7:0]  rdata_nxt, rdata_r;
    logic        cw_wr;
    logic [1:0]  sel;
    assign gate  = {speaker_gate, 2'h3};
    assign cw_wr = io_wr && (addr == tci_pkg::PORT_CMD[1:0]);
    assign sel   = wdata[tci_pkg::CW_SEL_HI:tci_pkg::CW_SEL_LO];

    function automatic logic [15:0] dec(input logic [15:0] v, input logic b,
                                        input logic [15:0] step);
        logic [15:0] r;
        logic [3:0]  d;
        logic        br;
        r  = v;
        br = 1'b0;
        if (!b) begin
            r = v - step;
        end else begin
            br = 1'b1;
            for (int k = 0; k < 4; k++) begin
                d = v[4*k +: 4];
                if (k == 0) begin
                    d = d - step[3:0];
                    br = (v[3:0] < step[3:0]);
                    if (br) begin
                        d = d - 4'h6;
                    end
                end else if (br) begin
                    br = (d == 4'h0);
                    d  = br ? 4'h9 : d - 4'h1;
                end
                r[4*k +: 4] = d;
            end
        end
        return r;
    endfunction : dec

    always_comb begin
        rdata_nxt = rdata_r;
        for (int i = 0; i < 3; i++) begin
            ce_nxt[i]           = ce_r[i];
            init_nxt[i]         = init_r[i];
            output_latch_nxt[i] = output_latch_r[i];
            mode_nxt[i]         = mode_r[i];
            acc_nxt[i]          = acc_r[i];
            st_nxt[i]           = st_r[i];
            bcd_nxt[i]          = bcd_r[i];
            out_nxt[i]          = out_r[i];
            null_nxt[i]         = null_r[i];
            pend_nxt[i]         = pend_r[i];
            olv_nxt[i]          = olv_r[i];
            stv_nxt[i]          = stv_r[i];
            wph_nxt[i]          = wph_r[i];
            rph_nxt[i]          = rph_r[i];
            // Counting element
            if (cnt_en && gate[i]) begin
                if (pend_r[i]) begin
                    ce_nxt[i]   = init_r[i];
                    pend_nxt[i] = 1'b0;
                    null_nxt[i] = 1'b0;
                    out_nxt[i]  = 1'b1;
                end else if (mode_r[i][1:0] == tci_pkg::MODE_SQUARE) begin
                    if (ce_r[i] <= 16'h0002 && ce_r[i] != 16'h0000) begin
                        ce_nxt[i]  = init_r[i] & 16'hfffe;
                        out_nxt[i] = ~out_r[i];
                    end else begin
                        ce_nxt[i] = dec(ce_r[i] & 16'hfffe, bcd_r[i], 16'h0002);
                    end
                end else if (mode_r[i][1:0] == tci_pkg::MODE_RATE) begin
                    if (ce_r[i] == 16'h0001) begin
                        ce_nxt[i] = init_r[i];
                    end else begin
                        ce_nxt[i] = dec(ce_r[i], bcd_r[i], 16'h0001);
                    end
                    out_nxt[i] = (ce_nxt[i] != 16'h0001);
                end else begin
                    ce_nxt[i] = dec(ce_r[i], bcd_r[i], 16'h0001);
                end
            end
            if (!olv_r[i]) begin
                output_latch_nxt[i] = ce_nxt[i];
            end
            // Command word
            if (cw_wr && sel == 2'(i)) begin
                if (wdata[tci_pkg::CW_ACC_HI:tci_pkg::CW_ACC_LO] == tci_pkg::ACC_LATCH) begin
                    if (!olv_r[i]) begin
                        olv_nxt[i]          = 1'b1;
                        output_latch_nxt[i] = ce_r[i];
                    end
                end else begin
                    acc_nxt[i]  = wdata[tci_pkg::CW_ACC_HI:tci_pkg::CW_ACC_LO];
                    mode_nxt[i] = wdata[tci_pkg::CW_MODE_HI:tci_pkg::CW_MODE_LO];
                    bcd_nxt[i]  = wdata[tci_pkg::CW_BCD];
                    null_nxt[i] = 1'b1;
                    olv_nxt[i]  = 1'b0;
                    stv_nxt[i]  = 1'b0;
                    wph_nxt[i]  = 1'b0;
                    rph_nxt[i]  = 1'b0;
                end
            end
            if (cw_wr && sel == tci_pkg::SEL_READBACK && wdata[i+1]) begin
                if (!wdata[tci_pkg::RB_COUNT_N] && !olv_r[i]) begin
                    olv_nxt[i]          = 1'b1;
                    output_latch_nxt[i] = ce_r[i];
                end
                if (!wdata[tci_pkg::RB_STATUS_N] && !stv_r[i]) begin
                    stv_nxt[i] = 1'b1;
                    st_nxt[i]  = {out_r[i], null_r[i], acc_r[i], mode_r[i], bcd_r[i]};
                end
            end
            // Count port write, phase kept per counter
            if (io_wr && addr == 2'(i)) begin
                null_nxt[i] = 1'b1;
                case (acc_r[i])
                    tci_pkg::ACC_LSB: begin
                        init_nxt[i] = {8'h00, wdata};
                        pend_nxt[i] = 1'b1;
                    end
                    tci_pkg::ACC_MSB: begin
                        init_nxt[i] = {wdata, 8'h00};
                        pend_nxt[i] = 1'b1;
                    end
                    tci_pkg::ACC_WORD: begin
                        if (!wph_r[i]) begin
                            init_nxt[i][7:0] = wdata;
                        end else begin
                            init_nxt[i][15:8] = wdata;
                            pend_nxt[i]       = 1'b1;
                        end
                        wph_nxt[i] = ~wph_r[i];
                    end
                    default: begin
                        init_nxt[i] = init_r[i];
                    end
                endcase
            end
            // Count port read: status, latched count, then live
            if (io_rd && addr == 2'(i)) begin
                if (stv_r[i]) begin
                    rdata_nxt  = st_r[i];
                    stv_nxt[i] = 1'b0;
                end else begin
                    case (acc_r[i])
                        tci_pkg::ACC_MSB: begin
                            rdata_nxt  = output_latch_r[i][15:8];
                            olv_nxt[i] = 1'b0;
                        end
                        tci_pkg::ACC_WORD: begin
                            rdata_nxt = rph_r[i] ? output_latch_r[i][15:8]
                                                 : output_latch_r[i][7:0];
                            rph_nxt[i] = ~rph_r[i];
                            if (rph_r[i]) begin
                                olv_nxt[i] = 1'b0;
                            end
                        end
                        default: begin
                            rdata_nxt  = output_latch_r[i][7:0];
                            olv_nxt[i] = 1'b0;
                        end
                    endcase
                end
            end
        end
        if (io_rd && addr == tci_pkg::PORT_CMD[1:0]) begin
            rdata_nxt = tci_pkg::READ_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int i = 0; i < 3; i++) begin
                ce_r[i]           <= 16'h0000;
                init_r[i]         <= 16'h0000;
                output_latch_r[i] <= 16'h0000;
                mode_r[i]         <= tci_pkg::RST_MODE;
                acc_r[i]          <= tci_pkg::ACC_LSB;
                st_r[i]           <= 8'h00;
            end
            bcd_r   <= 3'h0;
            out_r   <= 3'h7;
            null_r  <= 3'h0;
            pend_r  <= 3'h0;
            olv_r   <= 3'h0;
            stv_r   <= 3'h0;
            wph_r   <= 3'h0;
            rph_r   <= 3'h0;
            rdata_r <= 8'h00;
        end else begin
            ce_r           <= ce_nxt;
            init_r         <= init_nxt;
            output_latch_r <= output_latch_nxt;
            mode_r         <= mode_nxt;
            acc_r          <= acc_nxt;
            st_r           <= st_nxt;
            bcd_r          <= bcd_nxt;
            out_r          <= out_nxt;
            null_r         <= null_nxt;
            pend_r         <= pend_nxt;
            olv_r          <= olv_nxt;
            stv_r          <= stv_nxt;
            wph_r          <= wph_nxt;
            rph_r          <= rph_nxt;
            rdata_r        <= rdata_nxt;
        end
    end
    assign rdata                 = rdata_r;
    assign system_tick_interrupt = out_r[0];
    assign refresh_request       = out_r[1];
    assign speaker_tone          = out_r[2];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_div;
        @(posedge mclk) disable iff (!nrst) cnt_en |=> !cnt_en [*8];
    endproperty
    a_div: assert property (p_div) else $error("Enable too frequent");
    property p_load;
        @(posedge mclk) disable iff (!nrst) (cnt_en && pend_r[0])
            |=> (ce_r[0] == $past(init_r[0]));
    endproperty
    a_load: assert property (p_load) else $error("Count not loaded");
    property p_null;
        @(posedge mclk) disable iff (!nrst) (io_wr && addr == 2'h0) |=> null_r[0];
    endproperty
    a_null: assert property (p_null) else $error("Null flag not set");
    property p_cw_ro;
        @(posedge mclk) disable iff (!nrst) (io_rd && addr == 2'h3) |=> rdata == 8'hff;
    endproperty
    a_cw_ro: assert property (p_cw_ro) else $error("Command word readable");
    property p_hold;
        @(posedge mclk) disable iff (!nrst) (olv_r[2] && !(io_rd && addr == 2'h2) && !cw_wr)
            |=> output_latch_r[2] == $past(output_latch_r[2]);
    endproperty
    a_hold: assert property (p_hold) else $error("Latch moved");
    property p_stfirst;
        @(posedge mclk) disable iff (!nrst) (stv_r[0] && io_rd && addr == 2'h0)
            |=> rdata == $past(st_r[0]);
    endproperty
    a_stfirst: assert property (p_stfirst) else $error("Status not first");
    property p_st_hold;
        @(posedge mclk) disable iff (!nrst) stv_r[0] |=> st_r[0] == $past(st_r[0]);
    endproperty
    a_st_hold: assert property (p_st_hold) else $error("Status latch moved");
    property p_rate;
        @(posedge mclk) disable iff (!nrst) $fell(refresh_request) |-> mode_r[1][1:0] == 2'b10;
    endproperty
    a_rate: assert property (p_rate) else $error("Unexpected low pulse");
    property p_gate;
        @(posedge mclk) disable iff (!nrst) (!speaker_gate && !pend_r[2])
            |=> ce_r[2] == $past(ce_r[2]);
    endproperty
    a_gate: assert property (p_gate) else $error("Gated counter moved");
    c_tick: cover property (@(posedge mclk) disable iff (!nrst) $rose(system_tick_interrupt));
    c_stat: cover property (@(posedge mclk) disable iff (!nrst) $fell(stv_r[0]));
    c_lat: cover property (@(posedge mclk) disable iff (!nrst) $fell(olv_r[2]));
endmodule : tci_timer

// [tb/tci_host.sv]
// Host model issuing byte I/O accesses to the timer
`timescale 1ns/100ps
module tci_host (
    input  wire logic       mclk,
    output logic      [1:0] addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    // ----------------
    // Bus tasks
    // ----------------
    initial begin
        addr  = 2'h0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        wdata = 8'h00;
    end
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        addr  = a;
        wdata = d;
        io_wr = 1'b1;
        @(posedge mclk);
        #1;
        io_wr = 1'b0;
        wdata = ~d;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        addr  = a;
        io_rd = 1'b1;
        @(posedge mclk);
        #1;
        io_rd = 1'b0;
        d     = rdata;
    endtask : rd
    // Both bytes, low first, never split
    task automatic wr16(input logic [1:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask : wr16
    task automatic rd16(input logic [1:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a, v[15:8]);
    endtask : rd16
endmodule : tci_host

// [tb/tci_timer_tb_top.sv]
// Self-checking bench for the interval timer
`timescale 1ns/100ps
module tci_timer_tb_top;
    logic        mclk;
    logic        nrst;
    logic [1:0]  addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        speaker_gate;
    logic        tick;
    logic        refr;
    logic        tone;
    logic [7:0]  b;
    logic [7:0]  s;
    logic [15:0] v1;
    logic [15:0] v2;
    int          fails;
    int          cmp_count;
    tci_timer dut (.mclk(mclk), .nrst(nrst), .addr(addr), .io_wr(io_wr), .io_rd(io_rd),
        .wdata(wdata), .rdata(rdata), .speaker_gate(speaker_gate),
        .system_tick_interrupt(tick), .refresh_request(refr), .speaker_tone(tone));
    tci_host host (.mclk(mclk), .addr(addr), .io_wr(io_wr), .io_rd(io_rd),
        .wdata(wdata), .rdata(rdata));
    // ----------------
    // Helpers
    // ----------------
    initial begin
        mclk = 1'b0;
        forever #(tci_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    function automatic logic pick(input int n);
        return (n == 0) ? tick : (n == 1) ? refr : tone;
    endfunction : pick
    // Skip to a clean edge, then time one high and one low phase
    task automatic meas(input int n, input int hi, input int lo);
        int ph[4];
        for (int i = 0; i < 4; i++) begin
            ph[i] = 0;
            while (pick(n) === !i[0] && ph[i] < 2000) begin
                @(posedge mclk);
                #1;
                ph[i]++;
            end
            if (ph[i] >= 2000) begin
                fails++;
                end_sim();
            end
        end
        chk(16'(ph[2]), 16'(hi));
        chk(16'(ph[3]), 16'(lo));
    endtask : meas
    initial begin
        fails = 0;
        cmp_count = 0;
        nrst = 1'b0;
        speaker_gate = 1'b1;
        repeat (10) @(posedge mclk);
        #1;
        nrst = 1'b1;
        chk({8'h00, rdata}, 16'h0000);
        chk({13'h0000, tick, refr, tone}, 16'h0007);
        host.rd(tci_pkg::PORT_CMD[1:0], b);
        chk({8'h00, b}, {8'h00, tci_pkg::READ_IDLE});
        $display("test reset and command read done");
        host.wr(2'h3, 8'h36);
        host.wr16(2'h0, 16'h0014);
        meas(0, 120, 120);
        $display("test square wave done");
        host.wr(2'h3, 8'h54);
        host.wr(2'h3, 8'he4);
        host.rd(2'h1, b);
        chk({8'h00, b & 8'h7f}, 16'h0054);
        host.wr(2'h1, 8'h05);
        meas(1, 48, 12);
        host.wr(2'h3, 8'he4);
        host.rd(2'h1, b);
        chk({8'h00, b & 8'h7f}, 16'h0014);
        $display("test rate mode done");
        host.wr(2'h3, 8'hb6);
        host.wr16(2'h2, 16'h000a);
        meas(2, 60, 60);
        speaker_gate = 1'b0;
        repeat (30) @(posedge mclk);
        #1;
        host.rd16(2'h2, v1);
        host.rd16(2'h2, v2);
        chk(v2, v1);
        host.wr(2'h3, 8'h80);
        speaker_gate = 1'b1;
        repeat (100) @(posedge mclk);
        host.wr(2'h3, 8'h80);
        host.rd16(2'h2, v2);
        chk(v2, v1);
        $display("test gate and latch done");
        host.wr(2'h3, 8'hc2);
        repeat (50) @(posedge mclk);
        host.wr(2'h3, 8'hc2);
        host.rd(2'h0, s);
        chk({8'h00, s & 8'h7f}, 16'h0036);
        host.rd(2'h0, v1[7:0]);
        host.rd(2'h2, b);
        host.rd(2'h0, v1[15:8]);
        chk({15'h0000, v1 <= 16'h0014 && !v1[0]}, 16'h0001);
        host.rd(2'h0, b);
        chk({15'h0000, b !== s}, 16'h0001);
        $display("test readback done");
        end_sim();
    end
endmodule : tci_timer_tb_top
